// file: irp_pkg.sv
// Purpose: Shared constants and carrier types for the prioritised interrupt receiver
// Assumes: Up to 32 request lines, 32-bit servicing master
// Notes:   Servicing addresses and drain time are defaults only; the top overrides only the drain time
package irp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned IRP_MAX_LINES = 32;
    localparam int unsigned IRP_ID_W      = 5;
    localparam int unsigned IRP_DEPTH_W   = 6;
    localparam int unsigned IRP_CNT_W     = 8;
    localparam int unsigned IRP_AW        = 32;
    localparam int unsigned IRP_DW        = 32;

    // Default servicing map: status word per sender, acknowledge word beside it
    localparam logic [IRP_AW-1:0] IRP_STATUS_BASE = 32'h0000_1000;
    localparam logic [IRP_AW-1:0] IRP_LINE_STRIDE = 32'h0000_0100;
    localparam logic [IRP_AW-1:0] IRP_ACK_OFS     = 32'h0000_0004;

    // Cycles a line may stay high after its acknowledge before it is serviced again
    localparam logic [IRP_CNT_W-1:0] IRP_DRAIN_CYCLES = 8'h10;

    // Reset values
    localparam logic [IRP_DEPTH_W-1:0] IRP_DEPTH_RST = 6'h00;
    localparam logic [IRP_CNT_W-1:0]   IRP_CNT_RST   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        IRP_IDLE,
        IRP_RD_SETUP,
        IRP_RD,
        IRP_WR_SETUP,
        IRP_WR,
        IRP_DRAIN
    } irp_state_e;

    typedef struct packed {
        logic [IRP_ID_W-1:0] line;
        logic [IRP_ID_W-1:0] rank;
        irp_state_e          resume;
        logic [IRP_DW-1:0]   status;
    } irp_ctx_s;

    typedef struct packed {
        logic [IRP_AW-1:0] address;
        logic              read;
        logic              write;
        logic [IRP_DW-1:0] writedata;
    } irp_mm_req_s;

    typedef struct packed {
        logic [IRP_DW-1:0] readdata;
        logic              waitrequest;
    } irp_mm_rsp_s;

    typedef struct packed {
        irp_state_e                     state;
        irp_ctx_s                       cur;
        irp_ctx_s [IRP_MAX_LINES-1:0]   stack;
        logic [IRP_DEPTH_W-1:0]         depth;
        logic [IRP_CNT_W-1:0]           drain_cnt;
        irp_mm_req_s                    mm;
        logic                           busy;
        logic                           done;
    } irp_top_s;

    // Rank table where line i has rank i; lower rank wins
    function automatic logic [IRP_MAX_LINES*IRP_ID_W-1:0] irp_identity_ranks();
        logic [IRP_MAX_LINES*IRP_ID_W-1:0] r;
        r = '0;
        for (int i = 0; i < IRP_MAX_LINES; i++) begin
            r[i*IRP_ID_W +: IRP_ID_W] = IRP_ID_W'(i);
        end
        return r;
    endfunction

endpackage

// file: irp_sync.sv
// Purpose: Two-stage synchroniser for the request vector
// Assumes: Requests are levels from any clock domain
// Notes:   The first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module irp_sync #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } irp_sync_s;

    irp_sync_s sync_ff;
    irp_sync_s nxt_sync;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_sync.meta   = din;
        nxt_sync.stable = sync_ff.meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff.stable;

endmodule // irp_sync
`default_nettype wire

// file: irp_receiver.sv
// Purpose: Prioritised, preemptive interrupt receiver with a servicing master
// Assumes: Senders hold their line until acknowledged through their own slave
// Notes:   Preemption happens only between bus transfers, never inside one
`timescale 1ns/10ps
`default_nettype none
module irp_receiver #(
    parameter int unsigned N = 32,
    parameter logic [irp_pkg::IRP_MAX_LINES*irp_pkg::IRP_ID_W-1:0] PRIO_RANK =
        irp_pkg::irp_identity_ranks(),
    parameter logic [irp_pkg::IRP_AW-1:0]    STATUS_BASE  = irp_pkg::IRP_STATUS_BASE,
    parameter logic [irp_pkg::IRP_AW-1:0]    LINE_STRIDE  = irp_pkg::IRP_LINE_STRIDE,
    parameter logic [irp_pkg::IRP_AW-1:0]    ACK_OFS      = irp_pkg::IRP_ACK_OFS,
    parameter logic [irp_pkg::IRP_CNT_W-1:0] DRAIN_CYCLES = irp_pkg::IRP_DRAIN_CYCLES
) (
    input  wire logic                              clk,
    input  wire logic                              reset_n,
    input  wire logic [N-1:0]                      irq_req,
    input  wire irp_pkg::irp_mm_rsp_s              mm_rsp,
    output irp_pkg::irp_mm_req_s                   mm_req,
    output logic                                   svc_busy,
    output logic [irp_pkg::IRP_ID_W-1:0]           svc_line,
    output logic [irp_pkg::IRP_DEPTH_W-1:0]        svc_depth,
    output logic                                   svc_done
);
    import irp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Request sampling

    logic [N-1:0]             req_sync;
    logic [IRP_MAX_LINES-1:0] pend;

    irp_sync #(
        .W       (N)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .din     (irq_req),
        .dout    (req_sync)
    );

    // Each line is its own level; nothing is latched, so a line that drops is no
    // longer pending even if it was never serviced. Lines above N read as quiet.
    genvar gi;

    generate
        for (gi = 0; gi < IRP_MAX_LINES; gi++) begin : g_pend
            if (gi < N) begin : g_used
                assign pend[gi] = req_sync[gi];
            end else begin : g_unused
                assign pend[gi] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Priority selection

    logic                best_valid;
    logic [IRP_ID_W-1:0] best_line;
    logic [IRP_ID_W-1:0] best_rank;

    // Ranks come from the table, not from the bit index; equal ranks fall to
    // the lower index so the choice stays deterministic
    always_comb begin
        best_valid = 1'b0;
        best_line  = '0;
        best_rank  = '0;
        for (int i = 0; i < N; i++) begin
            if (pend[i] && (!best_valid ||
                PRIO_RANK[i*IRP_ID_W +: IRP_ID_W] < best_rank)) begin
                best_valid = 1'b1;
                best_line  = IRP_ID_W'(i);
                best_rank  = PRIO_RANK[i*IRP_ID_W +: IRP_ID_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Servicing engine

    irp_top_s st_ff;
    irp_top_s nxt_st;

    logic                   preempt;
    logic                   at_boundary;
    logic [IRP_AW-1:0]      status_addr;
    logic [IRP_AW-1:0]      ack_addr;
    logic [IRP_ID_W-1:0]    top_idx;
    irp_ctx_s               top_ctx;

    // Preemption waits for a transfer boundary, so no bus cycle is abandoned half way;
    // the cost is up to one stalled transfer of extra latency for the stronger line
    assign at_boundary = (st_ff.state == IRP_RD_SETUP) || (st_ff.state == IRP_WR_SETUP) ||
                         (st_ff.state == IRP_DRAIN);

    // A full stack stops further preemption; the stronger line then waits its turn
    assign preempt = best_valid && st_ff.busy && (best_rank < st_ff.cur.rank) &&
                     (st_ff.depth < IRP_DEPTH_W'(IRP_MAX_LINES));

    assign status_addr = IRP_AW'(STATUS_BASE + IRP_AW'(st_ff.cur.line) * LINE_STRIDE);
    assign ack_addr    = IRP_AW'(status_addr + ACK_OFS);

    assign top_idx = IRP_ID_W'(st_ff.depth - IRP_DEPTH_W'(1));
    assign top_ctx = st_ff.stack[top_idx];

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;

        if (preempt && at_boundary) begin
            // Park the running handler where it stood and take the stronger line
            nxt_st.stack[st_ff.depth[IRP_ID_W-1:0]]        = st_ff.cur;
            nxt_st.stack[st_ff.depth[IRP_ID_W-1:0]].resume = st_ff.state;
            nxt_st.depth      = IRP_DEPTH_W'(st_ff.depth + IRP_DEPTH_W'(1));
            nxt_st.cur.line   = best_line;
            nxt_st.cur.rank   = best_rank;
            nxt_st.cur.resume = IRP_RD_SETUP;
            nxt_st.cur.status = '0;
            nxt_st.drain_cnt  = IRP_CNT_RST;
            nxt_st.state      = IRP_RD_SETUP;
        end else begin
            case (st_ff.state)
                IRP_IDLE: begin
                    if (best_valid) begin
                        nxt_st.busy       = 1'b1;
                        nxt_st.cur.line   = best_line;
                        nxt_st.cur.rank   = best_rank;
                        nxt_st.cur.resume = IRP_RD_SETUP;
                        nxt_st.cur.status = '0;
                        nxt_st.state      = IRP_RD_SETUP;
                    end
                end
                IRP_RD_SETUP: begin
                    nxt_st.mm.address = status_addr;
                    nxt_st.mm.read    = 1'b1;
                    nxt_st.state      = IRP_RD;
                end
                IRP_RD: begin
                    if (!mm_rsp.waitrequest) begin
                        nxt_st.mm.read    = 1'b0;
                        nxt_st.cur.status = mm_rsp.readdata;
                        nxt_st.state      = IRP_WR_SETUP;
                    end
                end
                IRP_WR_SETUP: begin
                    // Writing the status back clears exactly the causes that were seen
                    nxt_st.mm.address   = ack_addr;
                    nxt_st.mm.write     = 1'b1;
                    nxt_st.mm.writedata = st_ff.cur.status;
                    nxt_st.state        = IRP_WR;
                end
                IRP_WR: begin
                    if (!mm_rsp.waitrequest) begin
                        nxt_st.mm.write  = 1'b0;
                        nxt_st.drain_cnt = IRP_CNT_RST;
                        nxt_st.state     = IRP_DRAIN;
                    end
                end
                IRP_DRAIN: begin
                    if (!pend[st_ff.cur.line]) begin
                        // Sender has let go after its acknowledge
                        nxt_st.done      = 1'b1;
                        nxt_st.drain_cnt = IRP_CNT_RST;
                        if (st_ff.depth != IRP_DEPTH_RST) begin
                            nxt_st.cur   = top_ctx;
                            nxt_st.state = top_ctx.resume;
                            nxt_st.depth = IRP_DEPTH_W'(st_ff.depth - IRP_DEPTH_W'(1));
                        end else begin
                            nxt_st.busy  = 1'b0;
                            nxt_st.state = IRP_IDLE;
                        end
                    end else if (st_ff.drain_cnt == IRP_CNT_W'(DRAIN_CYCLES - 8'h01)) begin
                        // Still asserted: a fresh cause arrived, service it again.
                        // The window must outlast the synchroniser delay, or a line
                        // that let go properly is served a second time.
                        nxt_st.state = IRP_RD_SETUP;
                    end else begin
                        nxt_st.drain_cnt = IRP_CNT_W'(st_ff.drain_cnt + 8'h01);
                    end
                end
                default: begin
                    nxt_st.state = IRP_IDLE;
                end
            endcase
        end
    end

    // Asynchronous assert, clocked operation afterwards
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff       <= '0;
            st_ff.state <= IRP_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign mm_req    = st_ff.mm;
    assign svc_busy  = st_ff.busy;
    assign svc_line  = st_ff.cur.line;
    assign svc_depth = st_ff.depth;
    assign svc_done  = st_ff.done;

endmodule // irp_receiver
`default_nettype wire

// file: irp_receiver_asserts.sv
// Purpose: Port-level checks on the prioritised interrupt receiver
// Assumes: Default servicing address map
// Notes:   Bound to every receiver instance
`timescale 1ns/10ps
`default_nettype none
module irp_receiver_chk
    import irp_pkg::*;
#(
    parameter int unsigned N = 32
) (
    input wire logic                      clk,
    input wire logic                      reset_n,
    input wire logic [N-1:0]              irq_req,
    input wire irp_pkg::irp_mm_rsp_s      mm_rsp,
    input wire irp_pkg::irp_mm_req_s      mm_req,
    input wire logic                      svc_busy,
    input wire logic [IRP_ID_W-1:0]       svc_line,
    input wire logic [IRP_DEPTH_W-1:0]    svc_depth,
    input wire logic                      svc_done
);
    logic [N-1:0] req_d1_ff;
    logic [N-1:0] req_d2_ff;
    // Request history, so a service start can be tied to a line seen two edges earlier
    always_ff @(posedge clk) begin
        req_d1_ff <= irq_req;
        req_d2_ff <= req_d1_ff;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    a_read_holds: assert property (mm_req.read && mm_rsp.waitrequest |=>
        mm_req.read && $stable(mm_req.address)) else $error("read dropped while stalled");
    a_write_holds: assert property (mm_req.write && mm_rsp.waitrequest |=> mm_req.write
        && $stable(mm_req.address) && $stable(mm_req.writedata)) else $error("write unstable");
    a_one_kind: assert property (!(mm_req.read && mm_req.write))
        else $error("read and write together");
    a_read_addr: assert property ($rose(mm_req.read) |-> mm_req.address ==
        IRP_STATUS_BASE + IRP_AW'(svc_line) * IRP_LINE_STRIDE) else $error("bad status address");
    a_write_addr: assert property ($rose(mm_req.write) |-> mm_req.address ==
        IRP_STATUS_BASE + IRP_AW'(svc_line) * IRP_LINE_STRIDE + IRP_ACK_OFS)
        else $error("bad acknowledge address");
    a_idle_quiet: assert property (!svc_busy |-> !mm_req.read && !mm_req.write)
        else $error("bus access while idle");
    a_sync_delay: assert property ($rose(svc_busy) |-> req_d2_ff[svc_line])
        else $error("line taken before synchronised");
    a_done_pulse: assert property (svc_done && $stable(svc_depth) |=> !svc_done)
        else $error("done longer than one cycle");
    a_depth_step: assert property ($changed(svc_depth) |-> svc_depth == $past(svc_depth)
        + 6'h01 || svc_depth == $past(svc_depth) - 6'h01) else $error("depth jumped");
    a_reset_clear: assert property (disable iff (1'b0) !reset_n |-> !svc_busy &&
        !mm_req.read && !mm_req.write && svc_depth == 6'h00) else $error("not cleared in reset");
    c_preempt: cover property (svc_depth == 6'h01);
    c_stall: cover property (mm_req.read && mm_rsp.waitrequest);
    c_done: cover property (svc_done);
endmodule // irp_receiver_chk
bind irp_receiver irp_receiver_chk #(.N(N)) i_chk (.clk(clk), .reset_n(reset_n),
    .irq_req(irq_req), .mm_rsp(mm_rsp), .mm_req(mm_req), .svc_busy(svc_busy),
    .svc_line(svc_line), .svc_depth(svc_depth), .svc_done(svc_done));
`default_nettype wire

// file: irp_sender_model.sv
// Purpose: Four senders with their status and acknowledge slave
// Assumes: Default servicing address map
// Notes:   Slow mode stalls every transfer for two cycles
`timescale 1ns/10ps
`default_nettype none
module irp_sender_model
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic [3:0]            raise,
    input  wire logic                  slow,
    input  wire irp_pkg::irp_mm_req_s  mm_req,
    output irp_pkg::irp_mm_rsp_s       mm_rsp,
    output logic [3:0]                 irq_req
);
    import irp_pkg::*;
    logic [1:0] wait_ff;
    logic [7:0] junk_ff;
    logic       on_bus;
    assign on_bus = mm_req.read || mm_req.write;
    assign mm_rsp.waitrequest = slow && on_bus && (wait_ff != 2'h2);
    // Outside a completing read the data churns, so stale data is never trusted
    assign mm_rsp.readdata = (mm_req.read && !mm_rsp.waitrequest) ?
        32'h5A5A_0000 + {16'h0000, mm_req.address[15:0]} : {4{junk_ff}};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_ff <= 2'h0;
            junk_ff <= 8'h00;
            irq_req <= 4'h0;
        end else begin
            junk_ff <= junk_ff + 8'h35;
            wait_ff <= (on_bus && mm_rsp.waitrequest) ? wait_ff + 2'h1 : 2'h0;
            for (int i = 0; i < 4; i++) begin
                // A raise held over the acknowledge stands for a fresh cause
                if (raise[i]) begin
                    irq_req[i] <= 1'b1;
                end else if (mm_req.write && !mm_rsp.waitrequest && mm_req.address ==
                    IRP_STATUS_BASE + 32'(i) * IRP_LINE_STRIDE + IRP_ACK_OFS) begin
                    irq_req[i] <= 1'b0;
                end
            end
        end
    end
endmodule // irp_sender_model
`default_nettype wire

// file: irp_receiver_tb_top.sv
// Purpose: Self-checking bench for the interrupt receiver
// Assumes: Four lines, ranks reversed so line 3 wins
// Notes:   Acknowledge words identify the serviced line
`timescale 1ns/10ps
`default_nettype none
module irp_receiver_tb_top;
    import irp_pkg::*;
    function automatic logic [IRP_MAX_LINES*IRP_ID_W-1:0] reversed_ranks();
        logic [IRP_MAX_LINES*IRP_ID_W-1:0] r;
        for (int i = 0; i < IRP_MAX_LINES; i++) begin
            r[i*IRP_ID_W +: IRP_ID_W] = (i < 4) ? IRP_ID_W'(3 - i) : IRP_ID_W'(i);
        end
        return r;
    endfunction
    logic                   clk, reset_n, slow, svc_busy, svc_done;
    logic [3:0]             raise, irq_req;
    irp_mm_req_s            mm_req;
    irp_mm_rsp_s            mm_rsp;
    logic [IRP_ID_W-1:0]    svc_line;
    logic [IRP_DEPTH_W-1:0] svc_depth, max_depth;
    int                     fails, checks_done, dones;
    logic [31:0]            acks[$];
    irp_receiver #(.N(4), .PRIO_RANK(reversed_ranks()), .DRAIN_CYCLES(8'h04)) i_dut (
        .clk(clk), .reset_n(reset_n), .irq_req(irq_req), .mm_rsp(mm_rsp), .mm_req(mm_req),
        .svc_busy(svc_busy), .svc_line(svc_line), .svc_depth(svc_depth), .svc_done(svc_done));
    irp_sender_model i_peer (.clk(clk), .reset_n(reset_n), .raise(raise), .slow(slow),
        .mm_req(mm_req), .mm_rsp(mm_rsp), .irq_req(irq_req));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mm_req.write === 1'b1 && mm_rsp.waitrequest === 1'b0) acks.push_back(mm_req.writedata);
        if (svc_depth > max_depth) max_depth = svc_depth;
        if (svc_done === 1'b1) dones++;
    end
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ack_word(input int line);
        return 32'h5A5A_1000 + 32'(line) * 32'h0000_0100;
    endfunction
    task automatic pulse(input logic [3:0] v);
        @(negedge clk) raise = v;
        @(negedge clk) raise = 4'h0;
    endtask
    task automatic wait_read();
        repeat (100) @(negedge clk) if (mm_req.read === 1'b1) break;
    endtask
    // Bounded wait for n acknowledges and an idle receiver
    task automatic serve(input logic [3:0] v, input int n);
        pulse(v);
        repeat (400) @(negedge clk) if (acks.size() >= n && svc_busy === 1'b0) break;
        compare(32'(acks.size()), 32'(n));
    endtask
    task automatic t_single();
        acks.delete();
        serve(4'b1000, 1);
        compare(acks[0], ack_word(3));
        $display("test single done");
    endtask
    task automatic t_both();
        acks.delete();
        dones = 0;
        serve(4'b0101, 2);
        compare(acks[0], ack_word(2));
        compare(acks[1], ack_word(0));
        compare(32'(dones), 32'h2);
        $display("test priority done");
    endtask
    task automatic t_preempt();
        acks.delete();
        max_depth = 6'h00;
        slow = 1'b1;
        pulse(4'b0001);
        wait_read();
        compare(32'(svc_line), 32'h0);
        raise = 4'b1000;
        serve(4'h0, 2);
        compare(acks[0], ack_word(3));
        compare(acks[1], ack_word(0));
        compare(32'(max_depth), 32'h1);
        slow = 1'b0;
        $display("test preempt done");
    endtask
    // Line held over its acknowledge must be served again after the drain window
    task automatic t_rearm();
        acks.delete();
        @(negedge clk) raise = 4'b0100;
        repeat (100) @(negedge clk) if (acks.size() >= 1) break;
        raise = 4'h0;
        serve(4'h0, 2);
        compare(acks[0], ack_word(2));
        compare(acks[1], ack_word(2));
        $display("test rearm done");
    endtask
    task automatic t_reset();
        acks.delete();
        slow = 1'b1;
        pulse(4'b0010);
        wait_read();
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        compare(32'({svc_busy, svc_done, mm_req.read, mm_req.write, svc_depth}), 32'h0);
        reset_n = 1'b1;
        slow = 1'b0;
        serve(4'b0010, 1);
        compare(acks[0], ack_word(1));
        $display("test reset done");
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        {slow, raise, fails, checks_done, dones, max_depth} = '0;
        reset_n = 1'b1;
        #1 reset_n = 1'b0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        t_single();
        t_both();
        t_preempt();
        t_rearm();
        t_reset();
        stop_test();
    end
endmodule // irp_receiver_tb_top
`default_nettype wire
